//--- pkg/iowd_pkg.sv
/*
  Package for the I/O port watchdog: port address, interval limits,
  timing constants and the bus request carrier.
  Assumes a single 200 MHz system clock.
*/
package iowd_pkg;
  localparam logic [15:0] IOWD_PORT_ADDR = 16'h0443;
  localparam logic [7:0] IOWD_MIN_COUNT = 8'h01;
  localparam logic [7:0] IOWD_MAX_COUNT = 8'h3e;
  localparam logic [7:0] IOWD_READ_IDLE = 8'h00;
  localparam int IOWD_CLK_HZ = 200000000;
  localparam int IOWD_TICK_SEC = 1;
  localparam int IOWD_TICK_CYCLES_INT = IOWD_CLK_HZ * IOWD_TICK_SEC;
  localparam int IOWD_TICK_W = 28;
  localparam logic [IOWD_TICK_W-1:0] IOWD_TICK_CYCLES = IOWD_TICK_CYCLES_INT[IOWD_TICK_W-1:0];
  localparam logic IOWD_ACT_RESET = 1'b0;
  localparam logic IOWD_ACT_IRQ = 1'b1;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] data;
  } iowd_io_req_t;

  typedef enum logic [0:0] {
    IOWD_ST_IDLE = 1'b0,
    IOWD_ST_ARMED = 1'b1
  } iowd_state_t;
endpackage

//--- logic/iowd_watchdog.sv
/*
  I/O port watchdog: one byte-wide port. A write arms or refreshes the
  countdown, a read disarms it, and expiry pulses a CPU reset or an interrupt.
  Also holds the one-second enable divider that paces the countdown and the
  filter for the action select strap.
  Assumes one-cycle read/write strobes already on the system clock and a
  synchronous, active-high system reset.
*/
`timescale 1ns/1ps
// Functional notes
// R1: Port write loads interval and arms watchdog
// R2: Only intervals 01 to 3E are accepted
// R3: Timeout equals written count in seconds
// R4: Rewrite while armed reloads and restarts countdown
// R5: Port read disarms and stops countdown
// R6: Expiry asserts CPU reset or interrupt
// R7: Out-of-range writes ignored; disarmed after reset
module iowd_watchdog
  import iowd_pkg::*;
#(
  parameter logic [IOWD_TICK_W-1:0] TICK_CYCLES = IOWD_TICK_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire iowd_io_req_t i_io_req,
  input wire logic i_action_sel,
  output logic [7:0] o_rd_data,
  output logic o_armed,
  output logic o_cpu_reset,
  output logic o_irq
);
  // Registered state and the next values that feed it
  iowd_state_t state_reg, state_next;
  logic [7:0] count_reg, count_next;
  logic [IOWD_TICK_W-1:0] tick_reg, tick_next;
  logic action_reg, action_next;
  logic cpu_reset_reg, cpu_reset_next;
  logic irq_reg, irq_next;
  logic [7:0] rd_data_reg, rd_data_next;
  logic [2:0] sel_sync_reg;
  logic sel_filt_reg, sel_filt_next;

  // Port decode
  wire hit = (i_io_req.addr == IOWD_PORT_ADDR);
  wire wr_hit = hit && i_io_req.wr;
  wire rd_hit = hit && i_io_req.rd;

  // Interval range check; a refused write leaves every register alone
  wire data_low_ok = (i_io_req.data >= IOWD_MIN_COUNT); // [R2]
  wire data_high_ok = (i_io_req.data <= IOWD_MAX_COUNT); // [R2]
  wire in_range = data_low_ok && data_high_ok; // [R2] [R7]
  wire load = wr_hit && in_range; // [R1] [R4]
  wire drop = rd_hit && !load; // [R5]

  // Timing and expiry decode
  wire armed = (state_reg == IOWD_ST_ARMED);
  wire tick_last = (tick_reg == TICK_CYCLES - 1'b1);
  wire tick = armed && tick_last;
  wire last_second = (count_reg == 8'h01);
  wire expire = tick && last_second; // [R3]

  // An accepted write or a read in the expiry cycle wins, so no action is taken then
  wire fire = expire && !rd_hit && !load; // [R6]
  wire fire_reset = fire && (action_reg == IOWD_ACT_RESET);
  wire fire_irq = fire && (action_reg == IOWD_ACT_IRQ);

  // The strap may move at any time; a change counts once stages two and three agree
  wire sel_agree = (sel_sync_reg[1] == sel_sync_reg[2]);

  // One-second enable divider; restarted at every load so each interval is whole seconds
  always_comb begin
    tick_next = tick_reg;
    if (load || drop) begin
      tick_next = '0;
    end else if (!armed) begin
      tick_next = tick_reg;
    end else if (tick_last) begin
      tick_next = '0;
    end else begin
      tick_next = tick_reg + 1'b1;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      IOWD_ST_IDLE: begin
        if (load) begin
          state_next = IOWD_ST_ARMED; // [R1]
        end
      end
      IOWD_ST_ARMED: begin
        if (drop) begin
          state_next = IOWD_ST_IDLE; // [R5]
        end else if (load) begin
          state_next = IOWD_ST_ARMED; // [R4]
        end else if (expire) begin
          // Single-shot: stays idle until software writes again
          state_next = IOWD_ST_IDLE; // [R6]
        end
      end
      default: begin
        state_next = IOWD_ST_IDLE;
      end
    endcase
  end

  always_comb begin
    count_next = count_reg;
    if (load) begin
      count_next = i_io_req.data; // [R1] [R4]
    end else if (drop || expire) begin
      count_next = count_reg;
    end else if (tick) begin
      count_next = count_reg - 8'h01; // [R3]
    end
  end

  // Action select is captured only at a load so it cannot change mid-interval
  always_comb begin
    action_next = action_reg;
    if (load) begin
      action_next = sel_filt_reg;
    end
  end

  always_comb begin
    sel_filt_next = sel_filt_reg;
    if (sel_agree) begin
      sel_filt_next = sel_sync_reg[2];
    end
  end

  // Expiry outputs are one-cycle pulses; the system decides pulse stretching
  always_comb begin
    cpu_reset_next = fire_reset; // [R6]
    irq_next = fire_irq; // [R6]
  end

  // Reads always return the idle pattern; there is nothing else to report
  always_comb begin
    rd_data_next = rd_data_reg;
    if (rd_hit) begin
      rd_data_next = IOWD_READ_IDLE;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      state_reg <= IOWD_ST_IDLE; // [R7]
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      count_reg <= 8'h00;
    end else begin
      count_reg <= count_next;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      tick_reg <= '0;
    end else begin
      tick_reg <= tick_next;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      action_reg <= IOWD_ACT_RESET;
    end else begin
      action_reg <= action_next;
    end
  end

  // Three-stage capture of the strap; only stage two reads stage one
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      sel_sync_reg <= 3'h0;
    end else begin
      sel_sync_reg <= {sel_sync_reg[1:0], i_action_sel};
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      sel_filt_reg <= IOWD_ACT_RESET;
    end else begin
      sel_filt_reg <= sel_filt_next;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      cpu_reset_reg <= 1'b0;
    end else begin
      cpu_reset_reg <= cpu_reset_next;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      rd_data_reg <= 8'h00;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  // Every output comes straight from a register
  assign o_armed = armed;
  assign o_cpu_reset = cpu_reset_reg;
  assign o_irq = irq_reg;
  assign o_rd_data = rd_data_reg;
endmodule // iowd_watchdog

//--- bench/iowd_props.sv
/* Port checker for the watchdog.
   Assumes a bind from the bench. */
`timescale 1ns/1ps
module iowd_props import iowd_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire iowd_io_req_t i_io_req,
  input wire logic o_armed,
  input wire logic o_cpu_reset,
  input wire logic o_irq
);
  wire hit = i_io_req.addr == IOWD_PORT_ADDR;
  wire ok = hit && i_io_req.wr && i_io_req.data >= IOWD_MIN_COUNT && i_io_req.data <= IOWD_MAX_COUNT;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  arm_on_write_a: assert property (ok |=> o_armed) else $error("write did not arm");
  bad_write_a: assert property (!ok |=> !$rose(o_armed)) else $error("armed without valid write");
  read_off_a: assert property (hit && i_io_req.rd && !ok |=> !o_armed) else $error("read kept it armed");
  fire_a: assert property (o_cpu_reset || o_irq |-> $past(o_armed) && !o_armed) else $error("bad expiry");
  one_pulse_a: assert property (o_cpu_reset || o_irq |=> !o_cpu_reset && !o_irq) else $error("long pulse");
  reset_idle_a: assert property ($past(i_sys_rst) |-> !o_armed) else $error("armed after reset");
endmodule // iowd_props

//--- bench/iowd_host.sv
/* Host model issuing port cycles.
   Assumes the bench calls its task. */
`timescale 1ns/1ps
module iowd_host import iowd_pkg::*; (
  input wire logic i_mclk,
  output iowd_io_req_t o_req
);
  initial o_req = '0;
  // One-cycle write or read of the port
  task automatic cyc(input logic w, input logic [7:0] d);
    @(negedge i_mclk) o_req = {w, !w, IOWD_PORT_ADDR, d};
    @(negedge i_mclk) o_req = '0;
  endtask
endmodule // iowd_host

//--- bench/tb_io_port_watchdog_timer.sv
/* Bench for the watchdog, one tick = 4 cycles.
   Assumes the host model and checker. */
`timescale 1ns/1ps
module tb_io_port_watchdog_timer import iowd_pkg::*;;
  logic clk = 0, rst = 1, sel = 0, armed, crst, irq;
  logic [7:0] rdat;
  iowd_io_req_t req;
  int n_fail = 0, comparisons = 0, n;
  logic [8:0] rows [3] = '{9'h001, 9'h102, 9'h03e};
  initial forever #2.5 clk = ~clk;
  iowd_host h (.i_mclk(clk), .o_req(req));
  iowd_watchdog #(.TICK_CYCLES(28'h4)) i_dut (.i_mclk(clk), .i_sys_rst(rst), .i_io_req(req),
    .i_action_sel(sel), .o_rd_data(rdat), .o_armed(armed), .o_cpu_reset(crst), .o_irq(irq));
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (!ok) begin n_fail++; $display("wrong value at %0t: %s", $time, m); end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wait_fire(input int cnt);
    n = 0;
    while (crst !== 1'b1 && irq !== 1'b1 && n < 300) begin @(negedge clk); n++; end
    if (n >= 300) begin n_fail++; tally_and_finish(); end
    chk(n >= cnt * 4 - 1 && n <= cnt * 4 + 2 && irq === sel && armed === 1'b0, "expiry");
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst = 0;
    chk(armed === 1'b0 && rdat === 8'h00, "reset");
    foreach (rows[i]) begin
      sel = rows[i][8];
      repeat (4) @(negedge clk); // Let the strap filter settle before the load
      h.cyc(1, rows[i][7:0]);
      wait_fire(rows[i][7:0]);
    end
    h.cyc(1, 8'h02);
    repeat (5) @(negedge clk);
    h.cyc(1, 8'h02);
    wait_fire(2);
    h.cyc(1, 8'h3e);
    h.cyc(0, 8'h00);
    chk(armed === 1'b0 && rdat === IOWD_READ_IDLE, "read disarm");
    repeat (20) @(negedge clk);
    h.cyc(1, 8'h00);
    h.cyc(1, 8'h3f);
    chk(armed === 1'b0 && crst === 1'b0 && irq === 1'b0, "bad write");
    h.cyc(1, 8'h05);
    rst = 1;
    @(negedge clk) rst = 0;
    chk(armed === 1'b0, "mid reset");
    tally_and_finish();
  end
endmodule // tb_io_port_watchdog_timer
bind iowd_watchdog iowd_props i_props (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_io_req(i_io_req),
  .o_armed(o_armed), .o_cpu_reset(o_cpu_reset), .o_irq(o_irq));
